/* File: mtpc_map.svh */
`ifndef MTPC_MAP_SVH
`define MTPC_MAP_SVH

// ==========================================================================
// Register byte offsets on the APB slave.
`define MTPC_T1_CFG       8'h00
`define MTPC_T1_PER       8'h04
`define MTPC_T1_CNT       8'h08
`define MTPC_CH_CFG_BASE  8'h10
`define MTPC_CAP_BASE     8'h30
`define MTPC_SM_CFG_BASE  8'h50
`define MTPC_SM_CNT       8'h58

// ==========================================================================
// Channel counts, field widths and reset values.
`define MTPC_NUM_CH       5
`define MTPC_MAX_CH       5
`define MTPC_T1_CFG_W     16
`define MTPC_CH_CFG_W     20
`define MTPC_T1_PER_RST   16'hFFFF
`define MTPC_SM_CFG_RST   32'h00FF0000

`endif

/* File: mtpc_pkg.sv */
package mtpc_pkg;

  // ========================================================================
  // Channel modes and capture edge choices.
  typedef enum logic [1:0] {
    MTPC_CH_OFF = 2'h0,
    MTPC_CH_PWM = 2'h1,
    MTPC_CH_CAP = 2'h2
  } mtpc_ch_mode_e;

  typedef enum logic [1:0] {
    MTPC_EDGE_RISE = 2'h0,
    MTPC_EDGE_FALL = 2'h1,
    MTPC_EDGE_BOTH = 2'h2
  } mtpc_edge_e;

  // ========================================================================
  // Register layouts, msb first.
  typedef struct packed {
    logic [7:0] pre;
    logic [4:0] rsv;
    logic       evt;
    logic       ir;
    logic       en;
  } mtpc_t1_cfg_s;

  typedef struct packed {
    mtpc_edge_e    edge_sel;
    mtpc_ch_mode_e mode;
    logic [15:0]   cmp;
  } mtpc_ch_cfg_s;

  typedef struct packed {
    logic [7:0] cmp;
    logic [7:0] per;
    logic [7:0] pre;
    logic [6:0] rsv;
    logic       en;
  } mtpc_sm_cfg_s;

endpackage

/* File: mtpc_top.sv */
`timescale 1ns/1ps
`include "mtpc_map.svh"

module mtpc_top
  import mtpc_pkg::*;
#(
  parameter int unsigned NUM_CH = `MTPC_NUM_CH
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NUM_CH-1:0] cap_pin,
  input  wire logic              evt_pin,
  output logic      [NUM_CH-1:0] t1_out,
  output logic      [1:0]        sm_out
);

  // ========================================================================
  // Elaboration check: the address map holds at most five channels.
  if (NUM_CH < 1 || NUM_CH > `MTPC_MAX_CH) begin : g_bad_ch
    $error("NUM_CH out of range");
  end

  localparam int unsigned NI = NUM_CH + 1;

  // Word-aligned address match, shared by read and write decode.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Edge selection for one capture channel.
  function automatic logic edge_ok(input mtpc_edge_e sel, input logic r, input logic f);
    return (sel == MTPC_EDGE_RISE) ? r : (sel == MTPC_EDGE_FALL) ? f : (sel == MTPC_EDGE_BOTH) && (r || f);
  endfunction

  // ========================================================================
  // Input synchronizers.
  logic [NI-1:0] sy1_q;
  logic [NI-1:0] sy2_q;
  logic [NI-1:0] sy3_q;
  logic [NI-1:0] rise;
  logic [NI-1:0] fall;

  // two-stage synchronizer. Stage one feeds only stage two, so a pulse of
  // 1.5 clock periods is always seen; the third stage is the edge reference.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
    end else begin
      sy1_q <= {evt_pin, cap_pin};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // Edges are taken from the settled stages only.
  assign rise = sy2_q & ~sy3_q;
  assign fall = ~sy2_q & sy3_q;

  // ========================================================================
  // Register file and APB slave.
  mtpc_t1_cfg_s                    t1_q, t1_d;
  logic         [15:0]             per_q, per_d;
  mtpc_ch_cfg_s [NUM_CH-1:0]       ch_q, ch_d;
  mtpc_sm_cfg_s [1:0]              sm_q, sm_d;
  logic                            pready_q, pready_d;
  logic                            pslverr_q, pslverr_d;
  logic         [31:0]             prdata_q, prdata_d;
  logic         [31:0]             rd;
  logic                            ok;
  logic                            wr;
  logic         [15:0]             t1_cnt_q;
  logic         [NUM_CH-1:0][15:0] cap_q;
  logic         [1:0][7:0]         sm_cnt_q;

  // Decode, read mux and writes. A write lands only on the completing edge.
  always_comb begin
    t1_d  = t1_q;
    per_d = per_q;
    ch_d  = ch_q;
    sm_d  = sm_q;
    rd    = 32'h0;
    ok    = 1'b0;
    wr    = psel && penable && pready_q && pwrite;
    if (hit(paddr, `MTPC_T1_CFG)) begin
      ok = 1'b1;
      rd = {16'h0, t1_q};
      if (wr) begin
        t1_d     = mtpc_t1_cfg_s'(pwdata[`MTPC_T1_CFG_W-1:0]);
        t1_d.rsv = '0;
      end
    end
    if (hit(paddr, `MTPC_T1_PER)) begin
      ok = 1'b1;
      rd = {16'h0, per_q};
      if (wr) begin
        per_d = pwdata[15:0];
      end
    end
    if (hit(paddr, `MTPC_T1_CNT)) begin
      ok = 1'b1;
      rd = {16'h0, t1_cnt_q};
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit(paddr, 8'(`MTPC_CH_CFG_BASE + 4 * i))) begin
        ok = 1'b1;
        rd = {12'h0, ch_q[i]};
        if (wr) begin
          ch_d[i] = mtpc_ch_cfg_s'(pwdata[`MTPC_CH_CFG_W-1:0]);
        end
      end
      if (hit(paddr, 8'(`MTPC_CAP_BASE + 4 * i))) begin
        ok = 1'b1;
        rd = {16'h0, cap_q[i]};
      end
    end
    for (int j = 0; j < 2; j++) begin
      if (hit(paddr, 8'(`MTPC_SM_CFG_BASE + 4 * j))) begin
        ok = 1'b1;
        rd = sm_q[j];
        if (wr) begin
          sm_d[j]     = pwdata;
          sm_d[j].rsv = '0;
        end
      end
    end
    if (hit(paddr, `MTPC_SM_CNT)) begin
      ok = 1'b1;
      rd = {16'h0, sm_cnt_q[1], sm_cnt_q[0]};
    end
    // One wait state: pready rises the cycle after the access phase begins.
    pready_d  = psel && penable && !pready_q;
    pslverr_d = pready_d && !ok;
    prdata_d  = (pready_d && !pwrite) ? rd : 32'h0;
  end

  // Register stage for the register file and bus answer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t1_q      <= '0;
      per_q     <= `MTPC_T1_PER_RST;
      ch_q      <= '0;
      sm_q      <= {2{`MTPC_SM_CFG_RST}};
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      t1_q      <= t1_d;
      per_q     <= per_d;
      ch_q      <= ch_d;
      sm_q      <= sm_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ========================================================================
  // Timers.
  logic [7:0]              t1_pre_q, t1_pre_d;
  logic [15:0]             t1_cnt_d;
  logic [NUM_CH-1:0]       t1_out_q, t1_out_d;
  logic [NUM_CH-1:0][15:0] cap_d;
  logic [1:0][7:0]         sm_pre_q, sm_pre_d;
  logic [1:0][7:0]         sm_cnt_d;
  logic [1:0]              sm_out_q, sm_out_d;
  logic [1:0]              sm_ptick;
  logic [1:0]              sm_wrap;
  logic                    t1_ptick;
  logic                    t1_tick;

  // Next state of all counters, PWM outputs and capture registers.
  always_comb begin
    // small timers: prescaler, 8-bit counter and period.
    for (int j = 0; j < 2; j++) begin
      sm_ptick[j] = sm_q[j].en && (sm_pre_q[j] == sm_q[j].pre);
      sm_pre_d[j] = (!sm_q[j].en || sm_ptick[j]) ? 8'h00 : sm_pre_q[j] + 8'h01;
      sm_wrap[j]  = sm_ptick[j] && (sm_cnt_q[j] == sm_q[j].per);
      sm_cnt_d[j] = sm_wrap[j] ? 8'h00 : sm_ptick[j] ? sm_cnt_q[j] + 8'h01 : sm_cnt_q[j];
      // small timer PWM, high while below compare.
      sm_out_d[j] = sm_q[j].en && (sm_cnt_q[j] < sm_q[j].cmp);
    end
    // main prescaler divides the clock by pre plus one.
    t1_ptick = t1_q.en && (t1_pre_q == t1_q.pre);
    t1_pre_d = (!t1_q.en || t1_ptick) ? 8'h00 : t1_pre_q + 8'h01;
    // tick source: small timer 0 periods, event rising edges or prescaler.
    t1_tick = t1_q.en && (t1_q.ir ? sm_wrap[0] : t1_q.evt ? rise[NUM_CH] : t1_ptick);
    // main counter restart after the period value.
    t1_cnt_d = !t1_tick ? t1_cnt_q : (t1_cnt_q == per_q) ? 16'h0000 : t1_cnt_q + 16'h0001;
    for (int i = 0; i < NUM_CH; i++) begin
      // PWM channel, gated by small timer 0 in IR mode.
      t1_out_d[i] = (ch_q[i].mode == MTPC_CH_PWM) && (t1_cnt_q < ch_q[i].cmp) && (!t1_q.ir || sm_out_q[0]);
      // capture of the running count on the selected edge.
      cap_d[i] = ((ch_q[i].mode == MTPC_CH_CAP) && edge_ok(ch_q[i].edge_sel, rise[i], fall[i])) ? t1_cnt_q : cap_q[i];
    end
  end

  // Register stage for the timers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t1_pre_q <= 8'h00;
      t1_cnt_q <= 16'h0000;
      t1_out_q <= '0;
      cap_q    <= '0;
      sm_pre_q <= '0;
      sm_cnt_q <= '0;
      sm_out_q <= '0;
    end else begin
      t1_pre_q <= t1_pre_d;
      t1_cnt_q <= t1_cnt_d;
      t1_out_q <= t1_out_d;
      cap_q    <= cap_d;
      sm_pre_q <= sm_pre_d;
      sm_cnt_q <= sm_cnt_d;
      sm_out_q <= sm_out_d;
    end
  end

  assign t1_out = t1_out_q;
  assign sm_out = sm_out_q;

  // ========================================================================
  // Checks.
  chk_t1_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    t1_tick && (t1_cnt_q != per_q) |=> t1_cnt_q == $past(t1_cnt_q) + 16'h0001)
    else $error("main counter did not step on tick");

  chk_t1_count_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !t1_tick |=> $stable(t1_cnt_q))
    else $error("main counter moved without tick");

  chk_t1_prescale: assert property (@(posedge clk) disable iff (!rst_n)
    t1_q.en && !t1_ptick && $stable(t1_q) |=> t1_pre_q == $past(t1_pre_q) + 8'h01)
    else $error("prescaler did not advance");

  chk_t1_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    t1_tick && (t1_cnt_q == per_q) |=> t1_cnt_q == 16'h0000)
    else $error("main counter did not restart");

  chk_ch_pwm_level: assert property (@(posedge clk) disable iff (!rst_n)
    (ch_q[0].mode == MTPC_CH_PWM) && !t1_q.ir |=> t1_out_q[0] == $past(t1_cnt_q < ch_q[0].cmp))
    else $error("channel PWM level wrong");

  chk_ch_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (ch_q[0].mode == MTPC_CH_CAP) && (ch_q[0].edge_sel == MTPC_EDGE_RISE) && rise[0]
    |=> cap_q[0] == $past(t1_cnt_q))
    else $error("capture value wrong");

  chk_ir_gate_and: assert property (@(posedge clk) disable iff (!rst_n)
    t1_q.ir && !sm_out_q[0] |=> !t1_out_q[0])
    else $error("IR output not gated");

  chk_ir_tick_src: assert property (@(posedge clk) disable iff (!rst_n)
    t1_q.ir && !sm_wrap[0] |=> $stable(t1_cnt_q))
    else $error("IR mode counted without carrier period");

  chk_sm_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    sm_wrap[1] |=> sm_cnt_q[1] == 8'h00)
    else $error("small timer did not restart");

  chk_sm_pwm_level: assert property (@(posedge clk) disable iff (!rst_n)
    sm_q[0].en |=> sm_out_q[0] == $past(sm_cnt_q[0] < sm_q[0].cmp))
    else $error("small timer PWM level wrong");

  chk_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(rst_n, 2) |-> sy2_q[0] == $past(cap_pin[0], 2))
    else $error("synchronizer delay wrong");

  // A prescaled small timer must hold its count between ticks, not only step on them.
  chk_sm_tick_hold: assert property (@(posedge clk) disable iff (!rst_n)
    sm_q[0].en && !sm_ptick[0] |=> $stable(sm_cnt_q[0]))
    else $error("small timer moved between ticks");

  // Falling-edge mode must take the count on the falling edge of the settled input.
  chk_cap_fall_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (ch_q[0].mode == MTPC_CH_CAP) && (ch_q[0].edge_sel == MTPC_EDGE_FALL) && fall[0]
    |=> cap_q[0] == $past(t1_cnt_q))
    else $error("falling-edge capture value wrong");

endmodule

/* File: tb_mtpc_top.sv */
`timescale 1ns/1ps
`include "mtpc_map.svh"
// Compare two values, count the check and report a mismatch at once.
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) begin \
      n_errors++; \
      $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
    end \
  end

module tb_mtpc_top;
  // ==========================================================================
  // Stimulus and observation.
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  cap_pin = 5'h0;
  logic        evt_pin = 1'b0;
  logic [4:0]  t1_out;
  logic [1:0]  sm_out;
  wire  [6:0]  outs    = {sm_out, t1_out};
  int          n_errors = 0;
  int          checks   = 0;
  int          cyc      = 0;

  mtpc_top u_mtpc_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cap_pin(cap_pin), .evt_pin(evt_pin), .t1_out(t1_out), .sm_out(sm_out));

  // A 40 ns clock and a free cycle count for exact spacing of pin edges.
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ==========================================================================
  // Bus access. The request holds until pready is sampled high, then one idle
  // cycle follows so that psel is never assigned twice in one time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("[ERR] %0t bus wait timed out", $time);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // Count high cycles and rising edges of one output over n clocks.
  task automatic meas(input int s, input int n, output int hi, output int rs);
    logic p;
    hi = 0;
    rs = 0;
    p = outs[s];
    repeat (n) begin
      @(posedge clk);
      if (outs[s] === 1'b1) hi++;
      if (outs[s] === 1'b1 && p !== 1'b1) rs++;
      p = outs[s];
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    apb(1'b0, `MTPC_T1_PER, 32'h0, r, e);
    `CHK(r, 32'h0000FFFF)
    `CHK(e, 1'b0)
    rd(`MTPC_SM_CFG_BASE + 8'h04, r);
    `CHK(r, 32'h00FF0000)
    apb(1'b0, 8'hFC, 32'h0, r, e);
    `CHK(e, 1'b1)
    $display("t_reset done");
  endtask

  task automatic t_small();
    logic [31:0] r;
    int          hi;
    int          rs;
    wr(`MTPC_SM_CFG_BASE, 32'h03070101);
    wr(`MTPC_SM_CFG_BASE + 8'h04, 32'h02040001);
    rd(`MTPC_SM_CFG_BASE, r);
    `CHK(r, 32'h03070101)
    repeat (40) @(posedge clk);
    meas(5, 160, hi, rs);
    `CHK(hi, 60)
    `CHK(rs, 10)
    meas(6, 160, hi, rs);
    `CHK(hi, 64)
    `CHK(rs, 32)
    $display("t_small done");
  endtask

  // The main counter steps on small timer 0 wraps, so its pulse is gated.
  task automatic t_ir();
    int hi;
    int rs;
    wr(`MTPC_T1_PER, 32'h1);
    wr(`MTPC_CH_CFG_BASE, 32'h00010001);
    wr(`MTPC_T1_CFG, 32'h3);
    repeat (64) @(posedge clk);
    meas(0, 320, hi, rs);
    `CHK(hi, 60)
    `CHK(rs, 10)
    $display("t_ir done");
  endtask

  // Compares at zero, mid and above the period, for two prescaler settings.
  task automatic t_pwm();
    int hi;
    int rs;
    wr(`MTPC_T1_PER, 32'h9);
    wr(`MTPC_CH_CFG_BASE, 32'h00010004);
    wr(`MTPC_CH_CFG_BASE + 8'h04, 32'h0001000A);
    wr(`MTPC_CH_CFG_BASE + 8'h08, 32'h00010000);
    wr(`MTPC_CH_CFG_BASE + 8'h0C, 32'h00010006);
    wr(`MTPC_CH_CFG_BASE + 8'h10, 32'h00010002);
    for (int p = 0; p < 2; p++) begin
      wr(`MTPC_T1_CFG, {16'h0, p[7:0], 8'h01});
      repeat (40) @(posedge clk);
      meas(0, 200, hi, rs);
      `CHK(hi, 80)
      `CHK(rs, 20 / (p + 1))
      meas(1, 200, hi, rs);
      `CHK(hi, 200)
      meas(2, 200, hi, rs);
      `CHK(hi, 0)
      meas(3, 200, hi, rs);
      `CHK(hi, 120)
      meas(4, 200, hi, rs);
      `CHK(hi, 40)
    end
    $display("t_pwm done");
  endtask

  task automatic t_cap();
    logic [31:0] c;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] z;
    int          t0;
    wr(`MTPC_T1_PER, 32'hFFFF);
    wr(`MTPC_T1_CFG, 32'h1);
    repeat (37) @(posedge clk);
    wr(`MTPC_T1_CFG, 32'h0);
    rd(`MTPC_T1_CNT, c);
    // Counter stopped: rising-edge captures on channels 0 and 3 both hold it.
    wr(`MTPC_CH_CFG_BASE, 32'h00020000);
    wr(`MTPC_CH_CFG_BASE + 8'h0C, 32'h00020000);
    cap_pin <= 5'h09;
    repeat (2) @(posedge clk);
    cap_pin <= 5'h00;
    repeat (6) @(posedge clk);
    wr(`MTPC_CAP_BASE + 8'h0C, 32'h0);
    rd(`MTPC_CAP_BASE + 8'h0C, a);
    `CHK(a, c)
    rd(`MTPC_CAP_BASE, z);
    `CHK(z, c)
    `CHK(c != 0, 1'b1)
    // Counter running: both edges on channel 3, falling edge only on channel 0.
    wr(`MTPC_CH_CFG_BASE + 8'h0C, 32'h000A0000);
    wr(`MTPC_CH_CFG_BASE, 32'h00060000);
    wr(`MTPC_T1_CFG, 32'h1);
    t0 = cyc;
    cap_pin <= 5'h09;
    repeat (8) @(posedge clk);
    rd(`MTPC_CAP_BASE + 8'h0C, a);
    rd(`MTPC_CAP_BASE, z);
    `CHK(z, c)
    while (cyc < t0 + 20) @(posedge clk);
    cap_pin <= 5'h00;
    repeat (8) @(posedge clk);
    rd(`MTPC_CAP_BASE + 8'h0C, b);
    `CHK(b - a, 32'h14)
    rd(`MTPC_CAP_BASE, z);
    `CHK(z, b)
    $display("t_cap done");
  endtask

  task automatic t_evt();
    logic [31:0] c;
    logic [31:0] b;
    wr(`MTPC_T1_CFG, 32'h5);
    rd(`MTPC_T1_CNT, c);
    repeat (3) begin
      evt_pin <= 1'b1;
      repeat (2) @(posedge clk);
      evt_pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    rd(`MTPC_T1_CNT, b);
    `CHK(b, c + 32'h3)
    $display("t_evt done");
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence. IR runs before the period-9 test because a count left
  // above a smaller period would run on to the 16-bit wrap.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_small();
    t_ir();
    t_pwm();
    t_cap();
    t_evt();
    summarize();
  end

  // Watchdog well beyond the few thousand cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule
